//--- core/pmb_pkg.sv
// Purpose: Constants for the command-code register bank of a step-down power module
// Assumes: 10 MHz controller clock, transactions already decoded from the management bus
// Notes: Table order fixes the storage index of each read/write command
package pmb_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int SNAP_BYTES = 32;
   localparam int RW_COUNT = 43;

   // Transaction kinds
   localparam logic [1:0] KIND_SEND = 2'h0;
   localparam logic [1:0] KIND_BYTE = 2'h1;
   localparam logic [1:0] KIND_WORD = 2'h2;
   localparam logic [1:0] KIND_BLOCK = 2'h3;

   // Command codes used by the logic
   localparam logic [7:0] CMD_PHASE_OFFSET = 8'h37;
   localparam logic [7:0] CMD_TON_WAIT = 8'h60;
   localparam logic [7:0] CMD_TON_RAMP = 8'h61;
   localparam logic [7:0] CMD_TOFF_WAIT = 8'h64;
   localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
   localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD = 8'h79;
   localparam logic [7:0] CMD_STAT_VOUT = 8'h7A;
   localparam logic [7:0] CMD_STAT_IOUT = 8'h7B;
   localparam logic [7:0] CMD_STAT_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STAT_TEMP = 8'h7D;
   localparam logic [7:0] CMD_STAT_CML = 8'h7E;
   localparam logic [7:0] CMD_STAT_MON = 8'h80;
   localparam logic [7:0] CMD_RD_VIN = 8'h88;
   localparam logic [7:0] CMD_RD_VOUT = 8'h8B;
   localparam logic [7:0] CMD_RD_IOUT = 8'h8C;
   localparam logic [7:0] CMD_RD_TEMP1 = 8'h8D;
   localparam logic [7:0] CMD_RD_TEMP2 = 8'h8E;
   localparam logic [7:0] CMD_RD_DUTY = 8'h94;
   localparam logic [7:0] CMD_RD_FREQ = 8'h95;
   localparam logic [7:0] CMD_PROTO_VER = 8'h98;
   localparam logic [7:0] CMD_LOOP_SETUP = 8'hBC;
   localparam logic [7:0] CMD_LOOP_START = 8'hBD;
   localparam logic [7:0] CMD_GOOD_WAIT = 8'hD4;
   localparam logic [7:0] CMD_CAPTURE = 8'hEA;

   // Read/write commands and their reset values
   localparam logic [RW_COUNT-1:0][7:0] RW_CODES = {
      8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h44, 8'h45, 8'h46, 8'h4B, 8'h4F, 8'h50,
      8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E,
      8'h60, 8'h61, 8'h64, 8'h65, 8'hBC, 8'hBF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4,
      8'hD8, 8'hDD, 8'hDE, 8'hE0, 8'hE1, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hF0};
   localparam logic [RW_COUNT-1:0][15:0] RW_RESET = {
      16'h0000, 16'hC20F, 16'hBD4D, 16'h0000, 16'h0080, 16'h0000, 16'h0080, 16'hDB00,
      16'hDD00, 16'hEBE8, 16'h0080, 16'hEB70, 16'hE580, 16'hE490, 16'h0080, 16'hD3A0,
      16'h0080, 16'hD380, 16'hCA40, 16'hCA00, 16'h0080, 16'h0000, 16'hCA80, 16'hCA80,
      16'hCA80, 16'hCA80, 16'h0069, 16'h3838, 16'h6A11, 16'h2011, 16'h0000, 16'h0001,
      16'hBA00, 16'h0000, 16'h1414, 16'h8686, 16'h0000, 16'h0000, 16'h0080, 16'h0080,
      16'hD3C0, 16'hD440, 16'h0000};
   // One marks a byte-wide command, same order as above
   localparam logic [RW_COUNT-1:0] RW_IS_BYTE = 43'h05114410239;

   // Status field positions
   localparam int SB_VOUT = 5;
   localparam int SB_IOUT = 4;
   localparam int SB_INPUT = 3;
   localparam int SB_TEMP = 2;
   localparam int SB_CML = 1;
   localparam int SB_MON = 0;
   localparam int SW_VOUT = 15;
   localparam int SW_IOUT = 14;
   localparam int SW_INPUT = 13;
   localparam int SW_MON = 12;
   localparam int CML_BAD_CMD = 7;
   localparam int CML_BAD_DATA = 6;

   // Linear eleven format fields
   localparam int LIN_EXP_HI = 15;
   localparam int LIN_EXP_LO = 11;
   localparam int LIN_MAN_HI = 10;
   localparam int LIN_MAN_LO = 0;
   localparam int ADDR_PHASE_BITS = 4;

   typedef enum logic [2:0] {
      SEQ_OFF, SEQ_ON_WAIT, SEQ_RISE, SEQ_ON, SEQ_OFF_WAIT, SEQ_FALL
   } pmb_seq_t;
endpackage

//--- core/pmb_command_bank.sv
// Purpose: Command-code register bank with soft-start sequencer and output-good delay
// Assumes: Bus framing is done outside; one decoded transaction per txn_valid pulse
// Notes: Time words are linear eleven values in milliseconds
`timescale 1ns/1ns

// Contract
// R1 - Phase offset word is read/write; its reset value comes from the bus address.
// R2 - Every fault-action byte resets to 80h, shut down with no retry.
// R3 - Summary byte and category status bytes are read-only, 00h without faults.
// R4 - Status summary word is read-only, 0000h without faults.
// R5 - Measurements 88h-95h are read-only words; output voltage unsigned sixteen, others eleven.
// R6 - Command EAh is a read-only block returning a 32-byte capture.
// R7 - A send-byte to BDh starts loop auto-compensation.
// R8 - Loop tuning setup byte BCh is read/write, resets to 69h.
// R9 - On enable wait turn-on delay, then rise over rise time; both 5 ms.
// R10 - On disable wait turn-off delay, then fall over fall time; both 5 ms.
// R11 - Output-good pin asserts after delay word D4h (1 ms) once threshold met.
// R12 - Hot warning resets to EB70h, hot fault to EBE8h.
// R13 - Cold warning resets to E580h, cold fault to E490h.
// R14 - Input limits reset to D3A0h, D380h, CA40h and CA00h.
// R15 - Over-current limit resets to DB00h, under-current limit to DD00h.
// R16 - Averaged current limits reset D3C0h and D440h; their actions no retry.
// R17 - Current sense gain resets C20Fh, offset BD4Dh.
// R18 - Gate gap ceiling resets 3838h, default gap word 1414h.
// R19 - Adaptive gap setup word DEh resets to 8686h, disabled.
// R20 - Output limit detect setup byte D8h resets to 00h.
// R21 - Rail sequencing word resets 0000h; tracking byte E1h resets 00h.
// R22 - Phase control byte F0h resets 00h; load share word D2h 0000h.
// R23 - Eleven format: 5-bit signed exponent, 11-bit signed mantissa.
// R24 - Sixteen format: 16-bit mantissa with fixed exponent minus thirteen.
// R25 - Writes to read-only or unknown codes change nothing and flag a comm error.
// R26 - Host uses each command's transaction type and data length.
module pmb_command_bank
   import pmb_pkg::*;
#(
   parameter logic [15:0] OUT_HIGH_LIMIT_RESET = 16'h0000,
   parameter logic [15:0] OUT_LOW_LIMIT_RESET = 16'h0000,
   parameter logic [15:0] GOOD_THRESHOLD_RESET = 16'h0000,
   // Arbitrary value
   parameter logic [7:0] PROTO_VERSION = 8'h5A
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Strap
   input wire logic [6:0] bus_addr,
   // Decoded transactions
   input wire logic txn_valid,
   input wire logic [7:0] txn_cmd,
   input wire logic [1:0] txn_kind,
   input wire logic txn_write,
   input wire logic [15:0] txn_wdata,
   input wire logic [4:0] txn_index,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_err,
   // Power control
   input wire logic out_enable,
   input wire logic good_threshold_met,
   output logic output_good_pin,
   output logic ramp_up_active,
   output logic ramp_down_active,
   output logic output_on,
   output logic autocomp_start,
   output logic [15:0] phase_offset,
   output logic [7:0] loop_tuning,
   // Status sources
   input wire logic [7:0] vout_flags_in,
   input wire logic [7:0] iout_flags_in,
   input wire logic [7:0] input_flags_in,
   input wire logic [7:0] temp_flags_in,
   input wire logic [7:0] mon_flags_in,
   input wire logic clear_faults,
   input wire logic snap_capture,
   // Measurements
   input wire logic [15:0] meas_vin,
   input wire logic [15:0] meas_vout,
   input wire logic [15:0] meas_iout,
   input wire logic [15:0] meas_temp1,
   input wire logic [15:0] meas_temp2,
   input wire logic [15:0] meas_duty,
   input wire logic [15:0] meas_freq
);
   typedef struct packed {
      logic [RW_COUNT-1:0][15:0] regs;
      logic [SNAP_BYTES-1:0][7:0] snap;
      logic addr_loaded;
      logic [7:0] cml;
      pmb_seq_t seq;
      logic [31:0] seq_cnt;
      logic [31:0] good_cnt;
      logic good_out;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic rsp_err;
      logic ramp_up;
      logic ramp_down;
      logic out_on;
      logic comp_start;
   } pmb_state_t;

   pmb_state_t st_ff;
   pmb_state_t nxt_st;

   // Slot of a read/write command; bit 6 marks a hit
   function automatic logic [6:0] rw_find(input logic [7:0] code);
      logic [6:0] res;
      res = '0;
      for (int i = 0; i < RW_COUNT; i++) begin
         if (RW_CODES[i] == code) begin
            res = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   function automatic logic [5:0] rw_idx(input logic [7:0] code);
      logic [6:0] f;
      f = rw_find(code);
      return f[5:0];
   endfunction

   // Eleven format milliseconds to clock cycles; negative times read as zero
   function automatic logic [31:0] lin_cycles(input logic [15:0] v);
      logic signed [4:0] e;
      logic signed [10:0] m;
      logic [31:0] p;
      e = signed'(v[LIN_EXP_HI:LIN_EXP_LO]); // R23
      m = signed'(v[LIN_MAN_HI:LIN_MAN_LO]); // R23
      p = '0;
      if (m > 0) begin
         p = 32'(unsigned'(m[9:0])) * 32'(CYC_PER_MS);
         if (e < 0) begin
            p = p >> (-e);
         end else begin
            p = p << e;
         end
      end
      return p;
   endfunction

   function automatic logic [RW_COUNT-1:0][15:0] reset_table();
      logic [RW_COUNT-1:0][15:0] t;
      t = RW_RESET; // R2 R8 R9 R10 R11 R12 R13 R14 R15 R16 R17 R18 R19 R20 R21 R22
      t[rw_idx(8'h40)] = OUT_HIGH_LIMIT_RESET;
      t[rw_idx(8'h44)] = OUT_LOW_LIMIT_RESET;
      t[rw_idx(8'h5E)] = GOOD_THRESHOLD_RESET;
      return t;
   endfunction

   localparam pmb_state_t ST_RESET = '{
      regs: reset_table(), snap: '0, addr_loaded: 1'b0, cml: '0, seq: SEQ_OFF,
      seq_cnt: '0, good_cnt: '0, good_out: 1'b0, rsp_valid: 1'b0, rsp_data: '0,
      rsp_err: 1'b0, ramp_up: 1'b0, ramp_down: 1'b0, out_on: 1'b0, comp_start: 1'b0};

   always_comb begin
      logic [6:0] hit;
      logic [7:0] status_byte;
      logic [15:0] status_word;
      logic ro_ok;
      logic [15:0] ro_val;
      logic [1:0] ro_kind;
      logic cml_bad_cmd;
      logic cml_bad_data;
      hit = rw_find(txn_cmd);
      cml_bad_cmd = 1'b0;
      cml_bad_data = 1'b0;
      nxt_st = st_ff;
      nxt_st.rsp_valid = 1'b0;
      nxt_st.rsp_err = 1'b0;
      nxt_st.comp_start = 1'b0;

      // Summaries follow live flags and the latched CML byte, so 00h with no fault
      status_byte = '0;
      status_byte[SB_VOUT] = |vout_flags_in; // R3
      status_byte[SB_IOUT] = |iout_flags_in;
      status_byte[SB_INPUT] = |input_flags_in;
      status_byte[SB_TEMP] = |temp_flags_in;
      status_byte[SB_CML] = |st_ff.cml;
      status_byte[SB_MON] = |mon_flags_in;
      status_word = {8'h00, status_byte}; // R4
      status_word[SW_VOUT] = |vout_flags_in;
      status_word[SW_IOUT] = |iout_flags_in;
      status_word[SW_INPUT] = |input_flags_in;
      status_word[SW_MON] = |mon_flags_in;

      // Read-only decode
      ro_ok = 1'b1;
      ro_kind = KIND_WORD;
      ro_val = '0;
      case (txn_cmd)
         CMD_STAT_BYTE: begin
            ro_kind = KIND_BYTE; // R3
            ro_val = {8'h00, status_byte};
         end
         CMD_STAT_WORD: ro_val = status_word; // R4
         CMD_STAT_VOUT: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, vout_flags_in};
         end
         CMD_STAT_IOUT: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, iout_flags_in};
         end
         CMD_STAT_INPUT: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, input_flags_in};
         end
         CMD_STAT_TEMP: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, temp_flags_in};
         end
         CMD_STAT_CML: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, st_ff.cml};
         end
         CMD_STAT_MON: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, mon_flags_in};
         end
         CMD_RD_VIN: ro_val = meas_vin; // R5
         CMD_RD_VOUT: ro_val = meas_vout; // R5 R24
         CMD_RD_IOUT: ro_val = meas_iout;
         CMD_RD_TEMP1: ro_val = meas_temp1;
         CMD_RD_TEMP2: ro_val = meas_temp2;
         CMD_RD_DUTY: ro_val = meas_duty;
         CMD_RD_FREQ: ro_val = meas_freq;
         CMD_PROTO_VER: begin
            ro_kind = KIND_BYTE;
            ro_val = {8'h00, PROTO_VERSION};
         end
         CMD_CAPTURE: begin
            ro_kind = KIND_BLOCK; // R6
            ro_val = {8'h00, st_ff.snap[txn_index]};
         end
         default: ro_ok = 1'b0;
      endcase

      // Phase offset default follows the strap, caught once after reset
      if (!st_ff.addr_loaded) begin
         nxt_st.addr_loaded = 1'b1;
         nxt_st.regs[rw_idx(CMD_PHASE_OFFSET)] = {12'h000, bus_addr[ADDR_PHASE_BITS-1:0]}; // R1
      end

      if (txn_valid) begin
         nxt_st.rsp_valid = 1'b1;
         if (txn_cmd == CMD_LOOP_START) begin
            if (txn_kind == KIND_SEND) begin
               nxt_st.comp_start = 1'b1; // R7
            end else begin
               cml_bad_data = 1'b1; // R26
            end
         end else if (hit[6]) begin
            if (txn_kind != (RW_IS_BYTE[hit[5:0]] ? KIND_BYTE : KIND_WORD)) begin
               cml_bad_data = 1'b1; // R26
            end else if (txn_write) begin
               if (RW_IS_BYTE[hit[5:0]]) begin
                  nxt_st.regs[hit[5:0]] = {8'h00, txn_wdata[7:0]};
               end else begin
                  nxt_st.regs[hit[5:0]] = txn_wdata;
               end
            end else begin
               nxt_st.rsp_data = st_ff.regs[hit[5:0]];
            end
         end else if (ro_ok && !txn_write) begin
            if (txn_kind == ro_kind) begin
               nxt_st.rsp_data = ro_val;
            end else begin
               cml_bad_data = 1'b1; // R26
            end
         end else begin
            cml_bad_cmd = 1'b1; // R25
         end
         nxt_st.rsp_err = cml_bad_cmd | cml_bad_data;
         if (cml_bad_cmd | cml_bad_data) begin
            nxt_st.rsp_data = '0;
         end
      end

      // New errors win over a clear in the same cycle
      if (clear_faults) begin
         nxt_st.cml = '0;
      end
      if (cml_bad_cmd) begin
         nxt_st.cml[CML_BAD_CMD] = 1'b1; // R25
      end
      if (cml_bad_data) begin
         nxt_st.cml[CML_BAD_DATA] = 1'b1;
      end

      if (snap_capture) begin
         nxt_st.snap = {80'h0, status_word, mon_flags_in, st_ff.cml, temp_flags_in,
            input_flags_in, iout_flags_in, vout_flags_in, meas_freq, meas_duty,
            meas_temp2, meas_temp1, meas_iout, meas_vout, meas_vin}; // R6
      end

      // Soft-start and soft-stop sequencer
      case (st_ff.seq)
         SEQ_OFF: begin
            if (out_enable) begin
               nxt_st.seq = SEQ_ON_WAIT;
               nxt_st.seq_cnt = lin_cycles(st_ff.regs[rw_idx(CMD_TON_WAIT)]); // R9
            end
         end
         SEQ_ON_WAIT: begin
            if (!out_enable) begin
               nxt_st.seq = SEQ_OFF;
            end else if (st_ff.seq_cnt == '0) begin
               nxt_st.seq = SEQ_RISE; // R9
               nxt_st.ramp_up = 1'b1;
               nxt_st.seq_cnt = lin_cycles(st_ff.regs[rw_idx(CMD_TON_RAMP)]);
            end else begin
               nxt_st.seq_cnt = st_ff.seq_cnt - 32'd1;
            end
         end
         SEQ_RISE: begin
            if (st_ff.seq_cnt == '0) begin
               nxt_st.seq = SEQ_ON; // R9
               nxt_st.ramp_up = 1'b0;
               nxt_st.out_on = 1'b1;
            end else begin
               nxt_st.seq_cnt = st_ff.seq_cnt - 32'd1;
            end
         end
         SEQ_ON: begin
            if (!out_enable) begin
               nxt_st.seq = SEQ_OFF_WAIT;
               nxt_st.seq_cnt = lin_cycles(st_ff.regs[rw_idx(CMD_TOFF_WAIT)]); // R10
            end
         end
         SEQ_OFF_WAIT: begin
            if (st_ff.seq_cnt == '0) begin
               nxt_st.seq = SEQ_FALL; // R10
               nxt_st.ramp_down = 1'b1;
               nxt_st.seq_cnt = lin_cycles(st_ff.regs[rw_idx(CMD_TOFF_RAMP)]);
            end else begin
               nxt_st.seq_cnt = st_ff.seq_cnt - 32'd1;
            end
         end
         SEQ_FALL: begin
            if (st_ff.seq_cnt == '0) begin
               nxt_st.seq = SEQ_OFF; // R10
               nxt_st.ramp_down = 1'b0;
               nxt_st.out_on = 1'b0;
            end else begin
               nxt_st.seq_cnt = st_ff.seq_cnt - 32'd1;
            end
         end
         default: nxt_st.seq = SEQ_OFF;
      endcase

      // Output good waits out the delay word while the threshold holds
      if (st_ff.seq == SEQ_ON && good_threshold_met) begin
         if (st_ff.good_cnt >= lin_cycles(st_ff.regs[rw_idx(CMD_GOOD_WAIT)])) begin
            nxt_st.good_out = 1'b1; // R11
         end else begin
            nxt_st.good_cnt = st_ff.good_cnt + 32'd1;
         end
      end else begin
         nxt_st.good_cnt = '0;
         nxt_st.good_out = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rsp_valid = st_ff.rsp_valid;
   assign rsp_data = st_ff.rsp_data;
   assign rsp_err = st_ff.rsp_err;
   assign output_good_pin = st_ff.good_out;
   assign ramp_up_active = st_ff.ramp_up;
   assign ramp_down_active = st_ff.ramp_down;
   assign output_on = st_ff.out_on;
   assign autocomp_start = st_ff.comp_start;
   assign phase_offset = st_ff.regs[rw_idx(CMD_PHASE_OFFSET)];
   assign loop_tuning = st_ff.regs[rw_idx(CMD_LOOP_SETUP)][7:0];
endmodule

//--- sim/pmb_command_bank_asserts.sv
// Purpose: Port-level checks of the command bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ns
module pmb_bank_chk
   import pmb_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Transactions
   input wire logic txn_valid,
   input wire logic [7:0] txn_cmd,
   input wire logic [1:0] txn_kind,
   input wire logic txn_write,
   input wire logic [15:0] txn_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_err,
   // Power control
   input wire logic good_threshold_met,
   input wire logic output_good_pin,
   input wire logic ramp_up_active,
   input wire logic ramp_down_active,
   input wire logic output_on,
   input wire logic autocomp_start,
   input wire logic [7:0] loop_tuning
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_rise_done; ramp_up_active ##1 !ramp_up_active; endsequence
   sequence s_fall_done; ramp_down_active ##1 !ramp_down_active; endsequence
   property p_answer; txn_valid |=> rsp_valid; endproperty
   property p_quiet; !txn_valid |=> !rsp_valid; endproperty
   property p_stat_ro; txn_valid && txn_write && (txn_cmd inside {[8'h78:8'h7E], 8'h80}) |=> rsp_err; endproperty
   property p_word_ro; txn_valid && txn_write && txn_cmd == CMD_STAT_WORD |=> rsp_valid && rsp_err; endproperty
   property p_meas_ro; txn_valid && txn_write && (txn_cmd inside {[8'h88:8'h95]}) |=> rsp_err; endproperty
   property p_start; txn_valid && txn_cmd == CMD_LOOP_START && txn_kind == KIND_SEND |=> autocomp_start; endproperty
   property p_start_cause; autocomp_start |-> $past(txn_valid) && $past(txn_cmd) == CMD_LOOP_START; endproperty
   property p_tune; txn_valid && txn_write && txn_cmd == CMD_LOOP_SETUP && txn_kind == KIND_BYTE
      |=> loop_tuning == $past(txn_wdata[7:0]); endproperty
   property p_rise_end; s_rise_done |-> output_on; endproperty
   property p_fall_end; s_fall_done |-> !output_on; endproperty
   property p_good; output_good_pin |-> $past(output_on) && $past(good_threshold_met); endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   a_quiet: assert property (p_quiet) else $error("stray answer");
   a_stat_ro: assert property (p_stat_ro) else $error("status byte stored");
   a_word_ro: assert property (p_word_ro) else $error("status word stored");
   a_meas_ro: assert property (p_meas_ro) else $error("reading stored");
   a_start: assert property (p_start) else $error("no start");
   a_start_cause: assert property (p_start_cause) else $error("stray start");
   a_tune: assert property (p_tune) else $error("setup lost");
   a_rise_end: assert property (p_rise_end) else $error("not on after rise");
   a_fall_end: assert property (p_fall_end) else $error("on after fall");
   a_good: assert property (p_good) else $error("stray good");
endmodule

bind pmb_command_bank pmb_bank_chk chk (.mclk, .nrst, .txn_valid, .txn_cmd, .txn_kind, .txn_write, .txn_wdata,
   .rsp_valid, .rsp_err, .good_threshold_met, .output_good_pin, .ramp_up_active, .ramp_down_active, .output_on,
   .autocomp_start, .loop_tuning);

//--- sim/pmb_host_model.sv
// Purpose: Management host presenting decoded transactions
// Assumes: One transaction per call, answer comes on the next edge
// Notes: Idle command and data fields are inverted so stale values never look valid
`timescale 1ns/1ns
module pmb_host
   import pmb_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Transactions
   output logic txn_valid = 1'h0,
   output logic [7:0] txn_cmd = 8'h00,
   output logic [1:0] txn_kind = 2'h0,
   output logic txn_write = 1'h0,
   output logic [15:0] txn_wdata = 16'h0000,
   output logic [4:0] txn_index = 5'h00
);
   task automatic xfer(input logic [7:0] c, input logic [1:0] k, input logic w, input logic [15:0] wd,
         input logic [4:0] ix);
      @(posedge mclk);
      txn_valid <= 1'h1;
      txn_cmd <= c;
      txn_kind <= k;
      txn_write <= w;
      txn_wdata <= wd;
      txn_index <= ix;
      @(posedge mclk);
      txn_valid <= 1'h0;
      txn_cmd <= ~c;
      txn_wdata <= ~wd;
   endtask
endmodule

//--- sim/pmb_command_bank_bench.sv
// Purpose: Self-checking bench for the command bank
// Assumes: Host model presents one transaction at a time
// Notes: Time words are shortened so the sequencer runs in tens of cycles
`timescale 1ns/1ns
module pmb_command_bank_bench;
   import pmb_pkg::*;
   typedef struct packed {logic [15:0] d; logic e; logic cd; logic st;} pmb_note_t;
   localparam logic [7:0] SC [8] = '{8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80, 8'h79};
   localparam logic [7:0] FC [5] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h80};
   localparam logic [7:0] MC [7] = '{8'h88, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h94, 8'h95};
   localparam logic [7:0] TC [5] = '{8'h60, 8'h61, 8'h64, 8'h65, 8'hD4};
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   logic [6:0] bus_addr;
   logic txn_valid, txn_write, rsp_valid, rsp_err, out_enable, good_threshold_met, clear_faults, snap_capture;
   logic output_good_pin, ramp_up_active, ramp_down_active, output_on, autocomp_start;
   logic [7:0] txn_cmd, loop_tuning;
   logic [1:0] txn_kind, k;
   logic [15:0] txn_wdata, rsp_data, phase_offset, ex;
   logic [4:0] txn_index;
   logic [7:0] flg [5];
   logic [15:0] ms [7];
   pmb_note_t notes [$];
   pmb_note_t nt;
   int error_cnt = 0;
   int compares = 0;
   int n, i;
   always #50 mclk = ~mclk;
   pmb_host host (.mclk, .txn_valid, .txn_cmd, .txn_kind, .txn_write, .txn_wdata, .txn_index);
   pmb_command_bank dut (.mclk, .nrst, .bus_addr, .txn_valid, .txn_cmd, .txn_kind, .txn_write, .txn_wdata,
      .txn_index, .rsp_valid, .rsp_data, .rsp_err, .out_enable, .good_threshold_met, .output_good_pin,
      .ramp_up_active, .ramp_down_active, .output_on, .autocomp_start, .phase_offset, .loop_tuning,
      .vout_flags_in(flg[0]), .iout_flags_in(flg[1]), .input_flags_in(flg[2]), .temp_flags_in(flg[3]),
      .mon_flags_in(flg[4]), .clear_faults, .snap_capture, .meas_vin(ms[0]), .meas_vout(ms[1]),
      .meas_iout(ms[2]), .meas_temp1(ms[3]), .meas_temp2(ms[4]), .meas_duty(ms[5]), .meas_freq(ms[6]));
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic op(input logic [7:0] c, input logic [1:0] kd, input logic w, input logic [15:0] wd,
         input logic [15:0] ed, input logic ee, input logic cd, input logic st = 1'h0, input logic [4:0] ix = 5'h00);
      notes.push_back('{ed, ee, cd, st});
      host.xfer(c, kd, w, wd, ix);
   endtask
   // Bounded wait; a hang is a mismatch
   task automatic wait_lvl(input int sel, input logic lvl);
      n = 0;
      while (((sel == 0) ? output_on : output_good_pin) !== lvl) begin
         @(posedge mclk);
         n++;
         if (n > 400) begin
            check("wait", 16'(lvl), 16'(~lvl));
            wrap_up();
         end
      end
   endtask
   always @(posedge mclk) begin
      if (rsp_valid === 1'h1) begin
         if (notes.size() == 0) begin
            check("answer", 16'h0000, 16'h0001);
         end else begin
            nt = notes.pop_front();
            if (nt.cd) check("data", nt.d, rsp_data);
            check("err", 16'(nt.e), 16'(rsp_err));
            check("start", 16'(nt.st), 16'(autocomp_start));
         end
      end
   end
   initial begin
      void'($urandom(52594));
      bus_addr = 7'($urandom());
      {out_enable, good_threshold_met, clear_faults, snap_capture} = 4'h0;
      foreach (flg[j]) flg[j] = 8'h00;
      foreach (ms[j]) ms[j] = 16'h0000;
      repeat (12) @(posedge mclk);
      nrst <= 1'h1;
      repeat (2) @(posedge mclk);
      for (int j = 0; j < RW_COUNT; j++) begin
         ex = (RW_CODES[j] == CMD_PHASE_OFFSET) ? {12'h000, bus_addr[3:0]} : RW_RESET[j];
         k = RW_IS_BYTE[j] ? KIND_BYTE : KIND_WORD;
         op(RW_CODES[j], k, 1'h0, 16'h0000, ex, 1'h0, 1'h1);
      end
      check("phase pin", {12'h000, bus_addr[3:0]}, phase_offset);
      $display("test reset values done");
      foreach (SC[j]) op(SC[j], (j == 7) ? KIND_WORD : KIND_BYTE, 1'h0, 16'h0, 16'h0, 1'h0, 1'h1);
      foreach (SC[j]) op(SC[j], (j == 7) ? KIND_WORD : KIND_BYTE, 1'h1, 16'h00FF, 16'h0, 1'h1, 1'h1);
      op(8'h7E, KIND_BYTE, 1'h0, 16'h0, 16'h0080, 1'h0, 1'h1);
      @(posedge mclk);
      clear_faults <= 1'h1;
      foreach (flg[j]) flg[j] <= 8'($urandom());
      @(posedge mclk);
      clear_faults <= 1'h0;
      op(8'h7E, KIND_BYTE, 1'h0, 16'h0, 16'h0000, 1'h0, 1'h1);
      foreach (FC[j]) op(FC[j], KIND_BYTE, 1'h0, 16'h0, {8'h00, flg[j]}, 1'h0, 1'h1);
      $display("test status done");
      @(posedge mclk);
      foreach (ms[j]) ms[j] <= 16'($urandom());
      snap_capture <= 1'h1;
      @(posedge mclk);
      snap_capture <= 1'h0;
      foreach (MC[j]) op(MC[j], KIND_WORD, 1'h0, 16'h0, ms[j], 1'h0, 1'h1);
      op(8'h8B, KIND_WORD, 1'h1, 16'h1234, 16'h0, 1'h1, 1'h1);
      for (int j = 0; j < 4; j++) op(CMD_CAPTURE, KIND_BLOCK, 1'h0, 16'h0, {8'h00, ms[j / 2][8 * (j % 2) +: 8]},
         1'h0, 1'h1, 1'h0, 5'(j));
      op(CMD_CAPTURE, KIND_BLOCK, 1'h0, 16'h0, 16'h0, 1'h0, 1'h1, 1'h0, 5'h16);
      $display("test readings done");
      repeat (12) begin
         i = $urandom_range(RW_COUNT - 1);
         ex = 16'($urandom());
         if (RW_IS_BYTE[i]) ex[15:8] = 8'h00;
         k = RW_IS_BYTE[i] ? KIND_BYTE : KIND_WORD;
         op(RW_CODES[i], k, 1'h1, ex, 16'h0, 1'h0, 1'h0);
         op(RW_CODES[i], k, 1'h0, 16'h0, ex, 1'h0, 1'h1);
      end
      op(CMD_LOOP_SETUP, KIND_BYTE, 1'h1, 16'h00A5, 16'h0, 1'h0, 1'h0);
      op(CMD_LOOP_SETUP, KIND_WORD, 1'h1, 16'h1234, 16'h0, 1'h1, 1'h1);
      op(8'h30, KIND_WORD, 1'h1, 16'h1234, 16'h0, 1'h1, 1'h1);
      op(CMD_LOOP_SETUP, KIND_BYTE, 1'h0, 16'h0, 16'h00A5, 1'h0, 1'h1);
      op(8'h7E, KIND_BYTE, 1'h0, 16'h0, 16'h00C0, 1'h0, 1'h1);
      op(CMD_LOOP_START, KIND_SEND, 1'h1, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1);
      op(CMD_LOOP_START, KIND_WORD, 1'h1, 16'h0, 16'h0, 1'h1, 1'h1, 1'h0);
      $display("test access done");
      foreach (TC[j]) op(TC[j], KIND_WORD, 1'h1, 16'hB001, 16'h0, 1'h0, 1'h0);
      @(posedge mclk);
      out_enable <= 1'h1;
      wait_lvl(0, 1'h1);
      check("rise span", 16'h0001, 16'(n >= 18));
      good_threshold_met <= 1'h1;
      wait_lvl(1, 1'h1);
      check("good delay", 16'h0001, 16'(n >= 9));
      out_enable <= 1'h0;
      wait_lvl(0, 1'h0);
      check("fall span", 16'h0001, 16'(n >= 18));
      check("good drop", 16'h0000, 16'(output_good_pin));
      $display("test sequencer done");
      n = 0;
      while (notes.size() != 0 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      check("drained", 16'h0000, 16'(notes.size()));
      wrap_up();
   end
endmodule
